// ===== mac_setup_defines.vh
/*
 * Register offsets, field positions and reset values of the MAC control block.
 * Assumes inclusion by bare name from the design file; definitions only.
 */
`ifndef MAC_SETUP_DEFINES_VH
`define MAC_SETUP_DEFINES_VH

`define OFS_CONTROL_ONE    8'h00
`define OFS_CONTROL_TWO    8'h04
`define OFS_CONTROL_THREE  8'h08
`define OFS_CONTROL_FOUR   8'h0C
`define OFS_MAX_FRAME      8'h10
`define OFS_B2B_GAP        8'h14
`define OFS_NB2B_GAP_LOW   8'h18
`define OFS_NB2B_GAP_HIGH  8'h1C
`define OFS_RETRANSMIT     8'h20
`define OFS_COLL_WINDOW    8'h24
`define OFS_STATION_LO     8'h28
`define OFS_STATION_HI     8'h2C
`define OFS_STATUS         8'h30

`define BIT_RX_ENABLE      0
`define BIT_PASS_ALL       1
`define BIT_PAUSE_RX       2
`define BIT_PAUSE_TX       3
`define BIT_LOOPBACK       4
`define CTRL_ONE_MASK      8'h1F
`define BIT_MAC_RESET      7
`define BIT_FULL_DUPLEX    0
`define BIT_LENGTH_CHECK   1
`define BIT_APPEND_CRC     4

`define RST_CONTROL_ONE    8'h00
`define RST_CONTROL_TWO    8'h80
`define RST_CONTROL_THREE  8'h00
`define RST_CONTROL_FOUR   8'h00
`define RST_MAX_FRAME      16'h0600
`define RST_B2B_GAP        8'h00
`define RST_NB2B_GAP       16'h0000
`define RST_RETRANSMIT     8'h0F
`define RST_COLL_WINDOW    8'h37
`define RST_STATION        48'h000000000000

`define RESP_OKAY          2'h0
`define RESP_SLVERR        2'h2

`endif

// ===== mac_control_setup.v
/*
 * MAC configuration registers on AXI4-Lite and the frame gating they steer.
 * Assumes a single 125 MHz clock; receive and transmit paths sit outside and
 * use the byte-wide frame strobes and the settings driven from here.
 */
`timescale 1ns/10ps
`include "mac_setup_defines.vh"

module mac_control_setup (
    input  wire        sys_clk,
    input  wire        rstn,
    input  wire [7:0]  s_axi_awaddr,
    input  wire        s_axi_awvalid,
    output wire        s_axi_awready,
    input  wire [31:0] s_axi_wdata,
    input  wire [3:0]  s_axi_wstrb,
    input  wire        s_axi_wvalid,
    output wire        s_axi_wready,
    output reg  [1:0]  s_axi_bresp,
    output reg         s_axi_bvalid,
    input  wire        s_axi_bready,
    input  wire [7:0]  s_axi_araddr,
    input  wire        s_axi_arvalid,
    output wire        s_axi_arready,
    output reg  [31:0] s_axi_rdata,
    output reg  [1:0]  s_axi_rresp,
    output reg         s_axi_rvalid,
    input  wire        s_axi_rready,
    input  wire [7:0]  rx_phy_data,
    input  wire        rx_phy_valid,
    input  wire        rx_phy_last,
    input  wire        rx_is_control,
    input  wire        rx_is_pause,
    input  wire        rx_filtered_out,
    input  wire [7:0]  tx_data,
    input  wire        tx_valid,
    input  wire        tx_last,
    input  wire        tx_pause_done,
    output reg  [7:0]  rx_buf_data,
    output reg         rx_buf_valid,
    output reg         rx_buf_last,
    output reg         rx_buf_too_long,
    output reg  [15:0] rx_buf_length,
    output reg         rx_length_report,
    output reg  [7:0]  tx_phy_data,
    output reg         tx_phy_valid,
    output reg         tx_phy_last,
    output wire        tx_hold,
    output wire        tx_too_long,
    output wire        mac_in_reset,
    output wire        pause_send_enable,
    output wire        full_duplex,
    output wire [2:0]  pad_config_field,
    output wire        append_crc,
    output wire [7:0]  b2b_gap,
    output wire [15:0] nb2b_gap,
    output wire [7:0]  retransmit_limit,
    output wire [7:0]  collision_window,
    output wire [47:0] station_address
);

////////////////////////////////////////////////////////////////////////////////

reg  [7:0]  mac_control_one_q;
reg  [7:0]  mac_control_two_q;
reg  [7:0]  mac_control_three_q;
reg  [7:0]  mac_control_four_q;
reg  [15:0] max_frame_length_q;
reg  [7:0]  b2b_gap_q;
reg  [15:0] nb2b_gap_q;
reg  [7:0]  retransmit_limit_q;
reg  [7:0]  collision_window_q;
reg  [47:0] station_address_q;
reg  [7:0]  aw_addr_q;
reg         aw_full_q;
reg  [31:0] w_data_q;
reg  [3:0]  w_strb_q;
reg         w_full_q;
reg  [15:0] rx_count_q;
reg  [15:0] tx_count_q;
reg         rx_drop_q;
reg         rx_in_frame_q;
reg         pause_active_q;
reg         rx_long_q;
reg         tx_long_q;

function known_offset;
    input [7:0] a;
    begin
        known_offset = (a[1:0] == 2'h0) && (a <= `OFS_STATUS);
    end
endfunction

function [7:0] merge_byte;
    input [7:0] old;
    input [7:0] nw;
    input       en;
    begin
        merge_byte = en ? nw : old;
    end
endfunction

////////////////////////////////////////////////////////////////////////////////
// Bus slave: address and data caught in either order, answer one cycle on

wire do_write = aw_full_q && w_full_q && !s_axi_bvalid;
wire do_read  = s_axi_arvalid && !s_axi_rvalid;

assign s_axi_awready = !aw_full_q;
assign s_axi_wready  = !w_full_q;
assign s_axi_arready = !s_axi_rvalid;

always @(posedge sys_clk) begin
    if (!rstn) begin
        aw_full_q    <= 1'b0;
        w_full_q     <= 1'b0;
        aw_addr_q    <= 8'h00;
        w_data_q     <= 32'h00000000;
        w_strb_q     <= 4'h0;
        s_axi_bvalid <= 1'b0;
        s_axi_bresp  <= `RESP_OKAY;
    end else begin
        if (s_axi_awvalid && !aw_full_q) begin
            aw_full_q <= 1'b1;
            aw_addr_q <= s_axi_awaddr;
        end
        if (s_axi_wvalid && !w_full_q) begin
            w_full_q <= 1'b1;
            w_data_q <= s_axi_wdata;
            w_strb_q <= s_axi_wstrb;
        end
        if (do_write) begin
            aw_full_q    <= 1'b0;
            w_full_q     <= 1'b0;
            s_axi_bvalid <= 1'b1;
            s_axi_bresp  <= known_offset(aw_addr_q) ? `RESP_OKAY : `RESP_SLVERR;
        end else if (s_axi_bvalid && s_axi_bready) begin
            s_axi_bvalid <= 1'b0;
        end
    end
end

// Any order of writes lands in the same state; each register is independent
always @(posedge sys_clk) begin
    if (!rstn) begin
        mac_control_one_q   <= `RST_CONTROL_ONE;
        mac_control_two_q   <= `RST_CONTROL_TWO;
        mac_control_three_q <= `RST_CONTROL_THREE;
        mac_control_four_q  <= `RST_CONTROL_FOUR;
        max_frame_length_q  <= `RST_MAX_FRAME;
        b2b_gap_q           <= `RST_B2B_GAP;
        nb2b_gap_q          <= `RST_NB2B_GAP;
        retransmit_limit_q  <= `RST_RETRANSMIT;
        collision_window_q  <= `RST_COLL_WINDOW;
        station_address_q   <= `RST_STATION;
    end else if (do_write) begin
        case (aw_addr_q)
            `OFS_CONTROL_ONE:
                mac_control_one_q <= merge_byte(mac_control_one_q, w_data_q[7:0] & `CTRL_ONE_MASK,
                                                w_strb_q[0]);
            `OFS_CONTROL_TWO:   mac_control_two_q   <= merge_byte(mac_control_two_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_CONTROL_THREE: mac_control_three_q <= merge_byte(mac_control_three_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_CONTROL_FOUR:  mac_control_four_q  <= merge_byte(mac_control_four_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_MAX_FRAME: begin
                max_frame_length_q[7:0]  <= merge_byte(max_frame_length_q[7:0], w_data_q[7:0], w_strb_q[0]);
                max_frame_length_q[15:8] <= merge_byte(max_frame_length_q[15:8], w_data_q[15:8], w_strb_q[1]);
            end
            `OFS_B2B_GAP:       b2b_gap_q <= merge_byte(b2b_gap_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_NB2B_GAP_LOW:  nb2b_gap_q[7:0] <= merge_byte(nb2b_gap_q[7:0], w_data_q[7:0], w_strb_q[0]);
            `OFS_NB2B_GAP_HIGH: nb2b_gap_q[15:8] <= merge_byte(nb2b_gap_q[15:8], w_data_q[7:0], w_strb_q[0]);
            `OFS_RETRANSMIT:    retransmit_limit_q <= merge_byte(retransmit_limit_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_COLL_WINDOW:   collision_window_q <= merge_byte(collision_window_q, w_data_q[7:0], w_strb_q[0]);
            `OFS_STATION_LO: begin
                station_address_q[7:0]   <= merge_byte(station_address_q[7:0], w_data_q[7:0], w_strb_q[0]);
                station_address_q[15:8]  <= merge_byte(station_address_q[15:8], w_data_q[15:8], w_strb_q[1]);
                station_address_q[23:16] <= merge_byte(station_address_q[23:16], w_data_q[23:16], w_strb_q[2]);
                station_address_q[31:24] <= merge_byte(station_address_q[31:24], w_data_q[31:24], w_strb_q[3]);
            end
            `OFS_STATION_HI: begin
                station_address_q[39:32] <= merge_byte(station_address_q[39:32], w_data_q[7:0], w_strb_q[0]);
                station_address_q[47:40] <= merge_byte(station_address_q[47:40], w_data_q[15:8], w_strb_q[1]);
            end
            default: ;
        endcase
    end
end

always @(posedge sys_clk) begin
    if (!rstn) begin
        s_axi_rvalid <= 1'b0;
        s_axi_rdata  <= 32'h00000000;
        s_axi_rresp  <= `RESP_OKAY;
    end else if (do_read) begin
        s_axi_rvalid <= 1'b1;
        s_axi_rresp  <= known_offset(s_axi_araddr) ? `RESP_OKAY : `RESP_SLVERR;
        case (s_axi_araddr)
            `OFS_CONTROL_ONE:   s_axi_rdata <= {24'h000000, mac_control_one_q & `CTRL_ONE_MASK};
            `OFS_CONTROL_TWO:   s_axi_rdata <= {24'h000000, mac_control_two_q};
            `OFS_CONTROL_THREE: s_axi_rdata <= {24'h000000, mac_control_three_q};
            `OFS_CONTROL_FOUR:  s_axi_rdata <= {24'h000000, mac_control_four_q};
            `OFS_MAX_FRAME:     s_axi_rdata <= {16'h0000, max_frame_length_q};
            `OFS_B2B_GAP:       s_axi_rdata <= {24'h000000, b2b_gap_q};
            `OFS_NB2B_GAP_LOW:  s_axi_rdata <= {24'h000000, nb2b_gap_q[7:0]};
            `OFS_NB2B_GAP_HIGH: s_axi_rdata <= {24'h000000, nb2b_gap_q[15:8]};
            `OFS_RETRANSMIT:    s_axi_rdata <= {24'h000000, retransmit_limit_q};
            `OFS_COLL_WINDOW:   s_axi_rdata <= {24'h000000, collision_window_q};
            `OFS_STATION_LO:    s_axi_rdata <= station_address_q[31:0];
            `OFS_STATION_HI:    s_axi_rdata <= {16'h0000, station_address_q[47:32]};
            `OFS_STATUS:        s_axi_rdata <= {27'h0000000, tx_long_q, rx_long_q, rx_in_frame_q,
                                                pause_active_q, mac_in_reset};
            default:            s_axi_rdata <= 32'h00000000;
        endcase
    end else if (s_axi_rvalid && s_axi_rready) begin
        s_axi_rvalid <= 1'b0;
    end
end

////////////////////////////////////////////////////////////////////////////////
// Settings handed to the rest of the MAC

assign mac_in_reset      = mac_control_two_q[`BIT_MAC_RESET];
assign pause_send_enable = mac_control_one_q[`BIT_PAUSE_TX];
assign full_duplex       = mac_control_three_q[`BIT_FULL_DUPLEX];
assign pad_config_field  = mac_control_three_q[7:5];
assign append_crc        = mac_control_three_q[`BIT_APPEND_CRC];
assign b2b_gap           = b2b_gap_q;
assign nb2b_gap          = nb2b_gap_q;
assign retransmit_limit  = retransmit_limit_q;
assign collision_window  = collision_window_q;
assign station_address   = station_address_q;

wire loop_on  = mac_control_one_q[`BIT_LOOPBACK];
wire rx_en    = mac_control_one_q[`BIT_RX_ENABLE];
wire pass_all = mac_control_one_q[`BIT_PASS_ALL];

// Loopback swaps the receive source and keeps the PHY silent
wire [7:0] rx_src_data  = loop_on ? tx_data : rx_phy_data;
wire       rx_src_valid = loop_on ? tx_valid : rx_phy_valid;
wire       rx_src_last  = loop_on ? tx_last : rx_phy_last;
wire       src_ctrl     = !loop_on && rx_is_control;

assign tx_hold     = pause_active_q || mac_in_reset;
assign tx_too_long = tx_long_q;

////////////////////////////////////////////////////////////////////////////////
// Frame gating; drop decision taken on a frame's first byte so frames never split

wire first_byte = rx_src_valid && !rx_in_frame_q;
wire drop_now   = first_byte ? (!rx_en || (src_ctrl && (!pass_all || rx_filtered_out))) : rx_drop_q;
wire [15:0] rx_next = rx_count_q + 16'h0001;
wire [15:0] tx_next = tx_count_q + 16'h0001;

always @(posedge sys_clk) begin
    if (!rstn || mac_in_reset) begin
        rx_in_frame_q    <= 1'b0;
        rx_drop_q        <= 1'b0;
        rx_count_q       <= 16'h0000;
        tx_count_q       <= 16'h0000;
        rx_long_q        <= 1'b0;
        tx_long_q        <= 1'b0;
        pause_active_q   <= 1'b0;
        rx_buf_data      <= 8'h00;
        rx_buf_valid     <= 1'b0;
        rx_buf_last      <= 1'b0;
        rx_buf_too_long  <= 1'b0;
        rx_buf_length    <= 16'h0000;
        rx_length_report <= 1'b0;
        tx_phy_data      <= 8'h00;
        tx_phy_valid     <= 1'b0;
        tx_phy_last      <= 1'b0;
    end else begin
        rx_buf_valid     <= 1'b0;
        rx_buf_last      <= 1'b0;
        rx_length_report <= 1'b0;
        if (rx_src_valid) begin
            rx_in_frame_q <= !rx_src_last;
            rx_drop_q     <= drop_now;
            rx_count_q    <= rx_src_last ? 16'h0000 : rx_next;
            if (rx_next > max_frame_length_q)
                rx_long_q <= 1'b1;
            else if (first_byte)
                rx_long_q <= 1'b0;
            if (!drop_now) begin
                rx_buf_data     <= rx_src_data;
                rx_buf_valid    <= 1'b1;
                rx_buf_last     <= rx_src_last;
                rx_buf_too_long <= rx_next > max_frame_length_q;
                if (rx_src_last) begin
                    rx_buf_length    <= rx_next;
                    rx_length_report <= mac_control_three_q[`BIT_LENGTH_CHECK];
                end
            end
        end
        // Pause frames are only seen from the PHY; loopback cannot pause itself
        if (!loop_on && rx_phy_valid && rx_phy_last && rx_is_pause && mac_control_one_q[`BIT_PAUSE_RX])
            pause_active_q <= 1'b1;
        else if (tx_pause_done)
            pause_active_q <= 1'b0;
        tx_phy_data  <= tx_data;
        tx_phy_valid <= tx_valid && !loop_on;
        tx_phy_last  <= tx_last && !loop_on;
        if (tx_valid) begin
            tx_count_q <= tx_last ? 16'h0000 : tx_next;
            if (tx_next > max_frame_length_q)
                tx_long_q <= 1'b1;
            else if (tx_count_q == 16'h0000)
                tx_long_q <= 1'b0;
        end
    end
end

endmodule

// ===== mac_setup_sva.sv
/*
 Checker for the MAC control block ports.
 Assumes binding into mac_control_setup; one clock, rstn low resets.
*/
`timescale 1ns/10ps
module mac_setup_sva (
    input wire logic        sys_clk,
    input wire logic        rstn,
    input wire logic        s_axi_bvalid,
    input wire logic        s_axi_bready,
    input wire logic [1:0]  s_axi_bresp,
    input wire logic        s_axi_rvalid,
    input wire logic        s_axi_rready,
    input wire logic [31:0] s_axi_rdata,
    input wire logic        rx_phy_valid,
    input wire logic        rx_phy_last,
    input wire logic        rx_is_pause,
    input wire logic        tx_valid,
    input wire logic [7:0]  tx_data,
    input wire logic        tx_pause_done,
    input wire logic        tx_phy_valid,
    input wire logic [7:0]  tx_phy_data,
    input wire logic        rx_buf_valid,
    input wire logic        rx_buf_last,
    input wire logic        rx_length_report,
    input wire logic        tx_hold,
    input wire logic        mac_in_reset
);
    default clocking cb @(posedge sys_clk); endclocking
    default disable iff (!rstn);
    AST_RST_QUIET: assert property (mac_in_reset && $past(mac_in_reset) |-> !rx_buf_valid && !tx_phy_valid)
        else $error("datapath active in reset");
    AST_RST_HOLD: assert property (mac_in_reset |-> tx_hold)
        else $error("tx not held in reset");
    AST_RX_SRC: assert property (rx_buf_valid |-> $past(rx_phy_valid || tx_valid))
        else $error("rx byte without source");
    AST_TX_PASS: assert property (tx_phy_valid |-> $past(tx_valid) && tx_phy_data == $past(tx_data))
        else $error("tx byte mismatch");
    AST_PAUSE_SET: assert property ($rose(tx_hold) && !mac_in_reset |-> $past(rx_phy_valid && rx_phy_last && rx_is_pause))
        else $error("hold without pause frame");
    AST_PAUSE_END: assert property (tx_pause_done && !rx_phy_valid && !mac_in_reset |=> !tx_hold || mac_in_reset)
        else $error("hold not released");
    AST_LEN_REPORT: assert property (rx_length_report |-> rx_buf_valid && rx_buf_last)
        else $error("length report off last byte");
    AST_B_STABLE: assert property (s_axi_bvalid && !s_axi_bready |=> s_axi_bvalid && $stable(s_axi_bresp))
        else $error("write response dropped");
    AST_R_STABLE: assert property (s_axi_rvalid && !s_axi_rready |=> s_axi_rvalid && $stable(s_axi_rdata))
        else $error("read data dropped");
endmodule
bind mac_control_setup mac_setup_sva chk (.sys_clk(sys_clk), .rstn(rstn),
    .s_axi_bvalid(s_axi_bvalid), .s_axi_bready(s_axi_bready), .s_axi_bresp(s_axi_bresp),
    .s_axi_rvalid(s_axi_rvalid), .s_axi_rready(s_axi_rready), .s_axi_rdata(s_axi_rdata),
    .rx_phy_valid(rx_phy_valid), .rx_phy_last(rx_phy_last), .rx_is_pause(rx_is_pause),
    .tx_valid(tx_valid), .tx_data(tx_data), .tx_pause_done(tx_pause_done),
    .tx_phy_valid(tx_phy_valid), .tx_phy_data(tx_phy_data), .rx_buf_valid(rx_buf_valid),
    .rx_buf_last(rx_buf_last), .rx_length_report(rx_length_report), .tx_hold(tx_hold),
    .mac_in_reset(mac_in_reset));

// ===== phy_model.sv
/*
 Receive side of the PHY: sends byte frames on request.
 Assumes the caller drives it from the bench clock domain.
*/
`timescale 1ns/10ps
module phy_model (
    input wire logic  sys_clk,
    output logic [7:0] rx_phy_data,
    output logic       rx_phy_valid,
    output logic       rx_phy_last,
    output logic       rx_is_control,
    output logic       rx_is_pause,
    output logic       rx_filtered_out
);
    initial {rx_phy_data, rx_phy_valid, rx_phy_last, rx_is_control, rx_is_pause, rx_filtered_out} = 13'h0000;
    task send(input int n, input logic c, input logic p, input logic f);
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            rx_phy_data <= 8'hA0 + i[7:0];
            rx_phy_valid <= 1'b1;
            rx_phy_last <= (i == n - 1);
            {rx_is_control, rx_is_pause, rx_filtered_out} <= {c, p, f};
        end
        @(posedge sys_clk);
        {rx_phy_valid, rx_phy_last, rx_is_control, rx_is_pause, rx_filtered_out} <= 5'h00;
        // Released data shows the inverse so a stale byte is never taken as fresh
        rx_phy_data <= ~rx_phy_data;
    endtask
endmodule

// ===== ethernet_mac_control_setup_test.sv
/*
 Self-checking bench for the MAC control block.
 Assumes the PHY model on the receive side; bench plays transmit engine and host.
*/
`timescale 1ns/10ps
module ethernet_mac_control_setup_test;
    logic sys_clk = 0, rstn = 0, awv = 0, wv = 0, bready = 0, arv = 0, rready = 0;
    logic [7:0] awaddr = 8'h00, araddr = 8'h00, tx_data = 8'h00;
    logic [31:0] wdata = 32'h0, rd;
    logic tx_valid = 0, tx_last = 0, tx_pause_done = 0;
    wire awready, wready, bvalid, arready, rvalid, rxv, rxl, rxc, rxp, rxf, rx_buf_valid, tx_phy_valid;
    wire rx_length_report, rx_buf_too_long, tx_hold, mac_in_reset;
    wire [1:0] bresp, rresp;
    wire [31:0] rdata;
    wire [7:0] rxd, b2b_gap;
    wire [15:0] rx_buf_length;
    wire [47:0] station_address;
    wire [7:0] rbd, rtl, cwin;
    wire [15:0] nb2b;
    wire [2:0] pad;
    wire tx_too_long, tx_phy_last, pse, fdx, crc;
    logic [1:0] rs;
    logic [7:0] last_rxd = 8'h00;
    // Late ready keeps an answer pending to exercise the stall path
    int late = 0;
    int n_errors = 0, check_count = 0, cyc = 0, n_rx, n_tx, n_len, n_long, n_tl;
    initial forever #4 sys_clk = ~sys_clk;
    phy_model phy (.sys_clk(sys_clk), .rx_phy_data(rxd), .rx_phy_valid(rxv), .rx_phy_last(rxl),
        .rx_is_control(rxc), .rx_is_pause(rxp), .rx_filtered_out(rxf));
    mac_control_setup uut (.sys_clk(sys_clk), .rstn(rstn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awv),
        .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(4'hF), .s_axi_wvalid(wv),
        .s_axi_wready(wready), .s_axi_bresp(bresp), .s_axi_bvalid(bvalid), .s_axi_bready(bready),
        .s_axi_araddr(araddr), .s_axi_arvalid(arv), .s_axi_arready(arready), .s_axi_rdata(rdata),
        .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready), .rx_phy_data(rxd),
        .rx_phy_valid(rxv), .rx_phy_last(rxl), .rx_is_control(rxc), .rx_is_pause(rxp),
        .rx_filtered_out(rxf), .tx_data(tx_data), .tx_valid(tx_valid), .tx_last(tx_last),
        .tx_pause_done(tx_pause_done), .rx_buf_data(rbd), .rx_buf_valid(rx_buf_valid), .rx_buf_last(),
        .rx_buf_too_long(rx_buf_too_long), .rx_buf_length(rx_buf_length),
        .rx_length_report(rx_length_report), .tx_phy_data(), .tx_phy_valid(tx_phy_valid),
        .tx_phy_last(tx_phy_last), .tx_hold(tx_hold), .tx_too_long(tx_too_long), .mac_in_reset(mac_in_reset),
        .pause_send_enable(pse), .full_duplex(fdx), .pad_config_field(pad), .append_crc(crc), .b2b_gap(b2b_gap),
        .nb2b_gap(nb2b), .retransmit_limit(rtl), .collision_window(cwin), .station_address(station_address));
    always @(posedge sys_clk) begin
        n_rx = n_rx + rx_buf_valid;
        n_tx = n_tx + tx_phy_valid;
        n_len = n_len + rx_length_report;
        n_long = n_long + (rx_buf_valid & rx_buf_too_long);
        n_tl = n_tl + tx_phy_last;
        if (rx_buf_valid) last_rxd = rx_buf_data_seen(rbd);
        cyc = cyc + 1;
        if (cyc == 20000) begin
            n_errors = n_errors + 1;
            final_report;
        end
    end
    ////////////////////////////////////////////////////////////
    task chk(input string nm, input logic [47:0] seen, input logic [47:0] exp);
        check_count++;
        if (seen !== exp) begin
            n_errors++;
            $display("wrong value %s expected %h seen %h", nm, exp, seen);
        end
    endtask
    // Ready is combinational: sample it mid-cycle, release after the edge
    function logic [7:0] rx_buf_data_seen(input logic [7:0] v);
        return v;
    endfunction
    task axw(input logic [7:0] a, input logic [31:0] d);
        logic ta, tw;
        int k;
        @(posedge sys_clk);
        {awaddr, wdata, awv, wv, bready} <= {a, d, 2'h3, late == 0};
        ta = 0;
        tw = 0;
        while (!(ta && tw)) begin
            @(negedge sys_clk);
            ta = ta | awready;
            tw = tw | wready;
            @(posedge sys_clk);
            if (ta) awv <= 0;
            if (tw) wv <= 0;
        end
        k = 0;
        do begin
            @(negedge sys_clk);
            rs = bresp;
            ta = bvalid && bready;
            @(posedge sys_clk);
            k++;
            if (k >= late && !ta) bready <= 1;
        end while (!ta);
        bready <= 0;
    endtask
    task axr(input logic [7:0] a);
        logic ta, tr;
        int k;
        @(posedge sys_clk);
        {araddr, arv, rready} <= {a, 1'b1, late == 0};
        ta = 0;
        tr = 0;
        k = 0;
        while (!tr) begin
            @(negedge sys_clk);
            ta = ta | arready;
            tr = rvalid && rready;
            {rd, rs} = {rdata, rresp};
            @(posedge sys_clk);
            if (ta) arv <= 0;
            k++;
            if (k >= late && !tr) rready <= 1;
        end
        rready <= 0;
    endtask
    task frame(input int n, input logic c, input logic p, input logic f);
        @(negedge sys_clk);
        {n_rx, n_tx, n_len, n_long} = 0;
        phy.send(n, c, p, f);
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    task txf(input int n);
        @(negedge sys_clk);
        {n_rx, n_tx, n_tl} = 0;
        for (int i = 0; i < n; i++) begin
            @(posedge sys_clk);
            {tx_data, tx_valid, tx_last} <= {i[7:0], 1'b1, i == n - 1};
        end
        @(posedge sys_clk);
        {tx_valid, tx_last} <= 0;
        repeat (3) @(posedge sys_clk);
        #1;
    endtask
    ////////////////////////////////////////////////////////////
    task t_init;
        chk("in reset", mac_in_reset, 1);
        axr(8'h04); chk("ctrl two", rd, 32'h80);
        axr(8'h10); chk("max frame", rd, 32'h600);
        axw(8'h00, 32'hFF); axr(8'h00); chk("ctrl one", rd, 32'h1F);
        axr(8'h40); chk("unmapped", {rs, rd}, {2'h2, 32'h0});
        axw(8'h28, 32'h33221100); axw(8'h2C, 32'h5544); axw(8'h14, 32'h15);
        chk("station", station_address, 48'h554433221100);
        chk("b2b gap", b2b_gap, 8'h15);
        $display("test init done");
    endtask
    task t_setup;
        chk("retx coll reset", {rtl, cwin}, 16'h0F37);
        late = 3;
        axw(8'h1C, 32'h0C); chk("wr resp", rs, 2'h0);
        axr(8'h1C); chk("gap high", {rs, rd}, {2'h0, 32'h0C});
        late = 0;
        axw(8'h18, 32'h12); chk("nb2b gap", nb2b, 16'h0C12);
        axw(8'h24, 32'h3F); chk("coll window", cwin, 8'h3F);
        axw(8'h08, 32'hF3); chk("pad crc dpx", {pad, crc, fdx}, 5'h1F);
        axw(8'h00, 32'h0D); chk("pause pair", pse, 1);
        $display("test setup done");
    endtask
    task t_rx;
        axw(8'h00, 32'h01); axw(8'h08, 32'h02); frame(4, 0, 0, 0);
        chk("rx in reset", n_rx, 0);
        axw(8'h04, 32'h0); frame(4, 0, 0, 0);
        chk("rx bytes", n_rx, 4);
        chk("len report", {n_len, rx_buf_length}, {32'd1, 16'd4});
        chk("rx data", last_rxd, 8'hA3);
        axw(8'h00, 32'h00); frame(4, 0, 0, 0);
        chk("rx disabled", n_rx, 0);
        $display("test rx done");
    endtask
    task t_ctrl;
        axw(8'h00, 32'h01); frame(4, 1, 0, 0); chk("ctrl drop", n_rx, 0);
        axw(8'h00, 32'h03); frame(4, 1, 0, 0); chk("ctrl pass", n_rx, 4);
        frame(4, 1, 0, 1); chk("ctrl filtered", n_rx, 0);
        $display("test ctrl done");
    endtask
    task t_pause;
        axw(8'h00, 32'h05); frame(4, 1, 1, 0); chk("hold set", tx_hold, 1);
        @(posedge sys_clk); tx_pause_done <= 1;
        @(posedge sys_clk); tx_pause_done <= 0;
        #1 chk("hold end", tx_hold, 0);
        axw(8'h00, 32'h01); frame(4, 1, 1, 0); chk("pause ignored", tx_hold, 0);
        $display("test pause done");
    endtask
    task t_loop;
        axw(8'h00, 32'h11); txf(3); chk("loop rx", {n_rx, n_tx}, {32'd3, 32'd0});
        chk("loop data", last_rxd, 8'h02);
        axw(8'h00, 32'h01); txf(3); chk("normal tx", {n_rx, n_tx, n_tl}, {32'd0, 32'd3, 32'd1});
        axw(8'h10, 32'h3); frame(4, 0, 0, 0); chk("too long", n_long, 1);
        frame(3, 0, 0, 0); chk("at max", n_long, 0);
        txf(4); chk("tx too long", tx_too_long, 1);
        axr(8'h30); chk("status", {rs, rd}, {2'h0, 32'h10});
        axw(8'h04, 32'h80); frame(4, 0, 0, 0);
        chk("reset again", {mac_in_reset, tx_hold, n_rx}, {2'h3, 32'd0});
        $display("test loop and length done");
    endtask
    task final_report;
        $display("checks %0d mismatches %0d", check_count, n_errors);
        if (n_errors == 0 && check_count > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    initial begin
        repeat (8) @(posedge sys_clk);
        rstn <= 1;
        #1;
        t_init; t_setup; t_rx; t_ctrl; t_pause; t_loop;
        final_report;
    end
endmodule
